// *** core/esc_engine.sv ***
// Enclave set-context leaf engine with AXI4-Lite register access
// ****************************************
// Engine top
// ****************************************
// Functional notes
// R1: Leaf selector 02H in EAX selects the set-context operation.
// R2: Operand addresses use the data segment only; overrides ignored.
// R3: Target page address not 4 KByte aligned gives general-protection fault, code zero.
// R4: After alignment, target outside protected page cache gives enclave page fault.
// R5: Context pointer not 8-byte aligned gives general-protection fault, code zero.
// R6: Load 64-bit context after alignment and cache checks, before conflict check.
// R7: Conflict sets ZF, clears CF, loads conflict code, skips the rest.
// R8: Invalid page-map entry gives enclave page fault.
// R9: After validity, wrong page type gives enclave page fault.
// R10: On success write context field, RAX zero, ZF cleared.
// R11: Success and conflict both clear CF, PF, AF, OF, SF.
// R12: 32-bit mode: over segment limit or unusable segment gives fault zero.
// R13: 64-bit mode: non-canonical operand address gives fault zero.
// R14: Paging fault on either operand reports page fault with error code.
// R15: Creating or reloading a control page sets context to its own address.
// R16: Only protected mode, not SMM or V86, and only with paging.
// R17: Extensions enabled only when enable bit 18 and lock bit 0 set.
// R18: Launch-key hash writable only when bit 17 and lock bit set.
// R19: Context field unchanged on any fault or conflict.
module esc_engine
	import esc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Memory and page-map side
	input wire esc_pmap_s pmap_info,
	input wire logic ds_limit_fault,
	input wire logic paging_fault_rcx,
	input wire logic paging_fault_rdx,
	input wire logic [63:0] mem_rdata,
	input wire logic page_create_pulse,
	input wire logic [63:0] page_create_addr,
	output logic irq
);

	// ****************************************
	// Register state
	// ****************************************
	logic [63:0] rcx_reg, rdx_reg, rax_reg, ctx_reg, ctx_next, key_reg, tmp_reg;
	logic [31:0] eax_reg, feat_reg, mode_reg;
	logic [2:0] res_reg;
	esc_flags_s flags_reg;
	logic [3:0] evt_reg, mask_reg;
	esc_state_e st_reg, st_next;
	logic awr_reg, wr_reg, bv_reg, arr_reg, rv_reg;
	logic [ADDR_W-1:0] awa_reg, ara_reg;
	logic [31:0] wd_reg, rd_reg;
	logic aw_have_reg, w_have_reg, rvpend_reg;

	// Mode word layout: bits follow esc_mode_s ordering
	esc_mode_s mode;
	assign mode = esc_mode_s'(mode_reg[5:0]);

	// ****************************************
	// Bus write capture
	// ****************************************
	wire aw_fire = s_axi_awvalid && awr_reg;
	wire w_fire = s_axi_wvalid && wr_reg;
	wire do_write = aw_have_reg && w_have_reg && !bv_reg;
	wire [ADDR_W-1:0] wa = awa_reg;
	wire feat_locked = feat_reg[ESC_FC_LOCK_BIT];
	wire key_wr_ok = feat_locked && feat_reg[ESC_FC_LEWR_BIT]; // R18
	wire enc_enabled = feat_locked && feat_reg[ESC_FC_EN_BIT]; // R17
	wire mode_ok = mode.protected_mode && !mode.smm && !mode.v86 && mode.paging; // R16
	wire go = do_write && (wa == ESC_OFF_CTRL) && wd_reg[0] && (st_reg == ESC_ST_IDLE);

	// Address and data latches; either may arrive first
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			awr_reg <= 1'b1;
			wr_reg <= 1'b1;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awa_reg <= '0;
			wd_reg <= '0;
			bv_reg <= 1'b0;
		end else begin
			if (aw_fire) begin
				awa_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
				awr_reg <= 1'b0;
			end
			if (w_fire) begin
				wd_reg <= s_axi_wdata;
				w_have_reg <= 1'b1;
				wr_reg <= 1'b0;
			end
			if (do_write) begin
				bv_reg <= 1'b1;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end
			if (bv_reg && s_axi_bready) begin
				bv_reg <= 1'b0;
				awr_reg <= 1'b1;
				wr_reg <= 1'b1;
			end
		end
	end

	// Software registers; feature word freezes once locked
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rcx_reg <= '0;
			rdx_reg <= '0;
			eax_reg <= '0;
			feat_reg <= ESC_FEAT_RESET;
			mode_reg <= ESC_MODE_RESET;
			mask_reg <= '0;
			key_reg <= '0;
		end else if (do_write) begin
			if (wa == ESC_OFF_RCX_LO) begin
				rcx_reg[31:0] <= wd_reg;
			end else if (wa == ESC_OFF_RCX_HI) begin
				rcx_reg[63:32] <= wd_reg;
			end else if (wa == ESC_OFF_RDX_LO) begin
				rdx_reg[31:0] <= wd_reg;
			end else if (wa == ESC_OFF_RDX_HI) begin
				rdx_reg[63:32] <= wd_reg;
			end else if (wa == ESC_OFF_RAX_LO) begin
				eax_reg <= wd_reg;
			end else if (wa == ESC_OFF_FEAT && !feat_locked) begin
				feat_reg <= wd_reg;
			end else if (wa == ESC_OFF_MODE) begin
				mode_reg <= wd_reg;
			end else if (wa == ESC_OFF_MASK) begin
				mask_reg <= wd_reg[3:0];
			end else if (wa == ESC_OFF_KEY_LO && key_wr_ok) begin
				key_reg[31:0] <= wd_reg; // R18
			end else if (wa == ESC_OFF_KEY_HI && key_wr_ok) begin
				key_reg[63:32] <= wd_reg; // R18
			end
		end
	end

	// ****************************************
	// Operand checks
	// ****************************************
	// Linear address is DS-relative with base zero; override prefixes never reach here
	wire [63:0] lin_rcx = rcx_reg; // R2
	wire [63:0] lin_rdx = rdx_reg; // R2
	wire rcx_canon_bad = (lin_rcx[63:47] != {17{lin_rcx[47]}});
	wire rdx_canon_bad = (lin_rdx[63:47] != {17{lin_rdx[47]}});
	wire canon_bad = mode.long64 && (rcx_canon_bad || rdx_canon_bad); // R13
	wire seg_bad = !mode.long64 && (mode.ds_unusable || ds_limit_fault); // R12
	wire rcx_misaligned = (lin_rcx[ESC_PAGE_ALIGN_BITS-1:0] != '0); // R3
	wire rdx_misaligned = (lin_rdx[ESC_CTX_ALIGN_BITS-1:0] != '0); // R5
	wire leaf_ok = (eax_reg == ESC_LEAF_SET_CONTEXT); // R1

	// ****************************************
	// Sequencer
	// ****************************************
	logic [2:0] fault_next;
	logic fault_hit;

	// Checks run in the documented order; first failure ends the leaf
	always_comb begin
		st_next = st_reg;
		fault_hit = 1'b0;
		fault_next = ESC_RES_OK;
		case (st_reg)
			ESC_ST_IDLE: begin
				if (go) begin
					st_next = ESC_ST_LOOKUP;
				end
			end
			ESC_ST_LOOKUP: begin
				st_next = ESC_ST_LOAD;
				if (!enc_enabled || !mode_ok || !leaf_ok) begin
					fault_hit = 1'b1; // R16
					fault_next = ESC_RES_UD; // R17
				end else if (seg_bad || canon_bad) begin
					fault_hit = 1'b1;
					fault_next = ESC_RES_GP; // R12
				end else if (rcx_misaligned) begin
					fault_hit = 1'b1;
					fault_next = ESC_RES_GP; // R3
				end else if (!pmap_info.in_cache || paging_fault_rcx) begin
					fault_hit = 1'b1;
					fault_next = ESC_RES_PF; // R4
				end else if (rdx_misaligned) begin
					fault_hit = 1'b1;
					fault_next = ESC_RES_GP; // R5
				end
			end
			ESC_ST_LOAD: begin
				st_next = ESC_ST_CHECK;
				if (paging_fault_rdx) begin
					fault_hit = 1'b1;
					fault_next = ESC_RES_PF; // R14
				end
			end
			ESC_ST_CHECK: begin
				st_next = ESC_ST_WRITE;
				if (pmap_info.busy) begin
					fault_hit = 1'b1;
					fault_next = ESC_RES_CONFLICT; // R7
				end else if (!pmap_info.valid) begin
					fault_hit = 1'b1;
					fault_next = ESC_RES_PF; // R8
				end else if (pmap_info.page_type != ESC_CONTROL_PAGE_TYPE) begin
					fault_hit = 1'b1;
					fault_next = ESC_RES_PF; // R9
				end
			end
			ESC_ST_WRITE: begin
				st_next = ESC_ST_DONE;
			end
			ESC_ST_DONE: begin
				st_next = ESC_ST_IDLE;
			end
			default: begin
				st_next = ESC_ST_IDLE;
			end
		endcase
		if (fault_hit) begin
			st_next = ESC_ST_DONE;
		end
	end

	// Context field: create/reload default, else success write only
	always_comb begin
		ctx_next = ctx_reg;
		if (page_create_pulse) begin
			ctx_next = page_create_addr; // R15
		end else if (st_reg == ESC_ST_WRITE) begin
			ctx_next = tmp_reg; // R10
		end
	end

	// State, temp value, result, flags
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_reg <= ESC_ST_IDLE;
			tmp_reg <= '0;
			ctx_reg <= '0;
			rax_reg <= '0;
			res_reg <= ESC_RES_OK;
			flags_reg <= '0;
		end else begin
			st_reg <= st_next;
			ctx_reg <= ctx_next; // R19
			if (st_reg == ESC_ST_LOAD) begin
				tmp_reg <= mem_rdata; // R6
			end
			if (fault_hit) begin
				res_reg <= fault_next;
			end
			if (fault_hit && fault_next == ESC_RES_CONFLICT) begin
				rax_reg <= ESC_PAGE_CONFLICT_CODE; // R7
				flags_reg <= '{zf: 1'b1, default: 1'b0}; // R11
			end else if (st_reg == ESC_ST_WRITE) begin
				rax_reg <= '0; // R10
				res_reg <= ESC_RES_OK;
				flags_reg <= '0; // R11
			end
		end
	end

	// ****************************************
	// Interrupt events
	// ****************************************
	// Bits: 0 done ok, 1 conflict, 2 general fault, 3 page fault or undefined
	logic [3:0] evt_set;
	wire rd_evt = rvpend_reg && (ara_reg == ESC_OFF_EVT); // Clear only once the word is captured
	assign evt_set[0] = (st_reg == ESC_ST_WRITE);
	assign evt_set[1] = fault_hit && (fault_next == ESC_RES_CONFLICT);
	assign evt_set[2] = fault_hit && (fault_next == ESC_RES_GP);
	assign evt_set[3] = fault_hit && (fault_next == ESC_RES_PF || fault_next == ESC_RES_UD);

	// Read clears; a new event in the same cycle still lands
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			evt_reg <= '0;
			irq <= 1'b0;
		end else begin
			evt_reg <= (rd_evt ? 4'h0 : evt_reg) | evt_set;
			irq <= |(((rd_evt ? 4'h0 : evt_reg) | evt_set) & mask_reg);
		end
	end

	// ****************************************
	// Bus read
	// ****************************************
	wire [31:0] stat_word = {26'h0, flags_reg};
	wire busy = (st_reg != ESC_ST_IDLE);
	logic [31:0] rmux;
	logic rok;

	// Unmapped reads answer SLVERR with zero data
	always_comb begin
		rok = 1'b1;
		rmux = 32'h0;
		if (ara_reg == ESC_OFF_CTRL) begin
			rmux = {31'h0, busy};
		end else if (ara_reg == ESC_OFF_STAT) begin
			rmux = stat_word;
		end else if (ara_reg == ESC_OFF_RCX_LO) begin
			rmux = rcx_reg[31:0];
		end else if (ara_reg == ESC_OFF_RCX_HI) begin
			rmux = rcx_reg[63:32];
		end else if (ara_reg == ESC_OFF_RDX_LO) begin
			rmux = rdx_reg[31:0];
		end else if (ara_reg == ESC_OFF_RDX_HI) begin
			rmux = rdx_reg[63:32];
		end else if (ara_reg == ESC_OFF_RAX_LO) begin
			rmux = rax_reg[31:0];
		end else if (ara_reg == ESC_OFF_RESULT) begin
			rmux = {29'h0, res_reg};
		end else if (ara_reg == ESC_OFF_FEAT) begin
			rmux = feat_reg;
		end else if (ara_reg == ESC_OFF_MODE) begin
			rmux = mode_reg;
		end else if (ara_reg == ESC_OFF_EVT) begin
			rmux = {28'h0, evt_reg};
		end else if (ara_reg == ESC_OFF_MASK) begin
			rmux = {28'h0, mask_reg};
		end else if (ara_reg == ESC_OFF_CTX_LO) begin
			rmux = ctx_reg[31:0];
		end else if (ara_reg == ESC_OFF_CTX_HI) begin
			rmux = ctx_reg[63:32];
		end else if (ara_reg == ESC_OFF_KEY_LO) begin
			rmux = key_reg[31:0];
		end else if (ara_reg == ESC_OFF_KEY_HI) begin
			rmux = key_reg[63:32];
		end else begin
			rok = 1'b0;
		end
	end

	logic [1:0] rresp_reg;

	// Address taken, then one cycle later data is registered
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			arr_reg <= 1'b1;
			ara_reg <= '0;
			rvpend_reg <= 1'b0;
			rv_reg <= 1'b0;
			rd_reg <= '0;
			rresp_reg <= 2'b00;
		end else begin
			if (s_axi_arvalid && arr_reg) begin
				ara_reg <= s_axi_araddr;
				arr_reg <= 1'b0;
				rvpend_reg <= 1'b1;
			end
			if (rvpend_reg) begin
				rd_reg <= rmux;
				rresp_reg <= rok ? 2'b00 : 2'b10;
				rv_reg <= 1'b1;
				rvpend_reg <= 1'b0;
			end
			if (rv_reg && s_axi_rready) begin
				rv_reg <= 1'b0;
				arr_reg <= 1'b1;
			end
		end
	end

	// Write response is OKAY for every address; unmapped writes are dropped
	assign s_axi_awready = awr_reg;
	assign s_axi_wready = wr_reg;
	assign s_axi_bvalid = bv_reg;
	assign s_axi_bresp = 2'b00;
	assign s_axi_arready = arr_reg;
	assign s_axi_rvalid = rv_reg;
	assign s_axi_rdata = rd_reg;
	assign s_axi_rresp = rresp_reg;

endmodule

// *** core/esc_pkg.sv ***
// Package of constants and types for the enclave set-context leaf engine
package esc_pkg;

	// ****************************************
	// Register map (AXI4-Lite byte offsets)
	// ****************************************
	localparam logic [7:0] ESC_OFF_CTRL = 8'h00;
	localparam logic [7:0] ESC_OFF_STAT = 8'h04;
	localparam logic [7:0] ESC_OFF_RCX_LO = 8'h08;
	localparam logic [7:0] ESC_OFF_RCX_HI = 8'h0c;
	localparam logic [7:0] ESC_OFF_RDX_LO = 8'h10;
	localparam logic [7:0] ESC_OFF_RDX_HI = 8'h14;
	localparam logic [7:0] ESC_OFF_RAX_LO = 8'h18;
	localparam logic [7:0] ESC_OFF_RESULT = 8'h1c;
	localparam logic [7:0] ESC_OFF_FEAT = 8'h20;
	localparam logic [7:0] ESC_OFF_MODE = 8'h24;
	localparam logic [7:0] ESC_OFF_EVT = 8'h28;
	localparam logic [7:0] ESC_OFF_MASK = 8'h2c;
	localparam logic [7:0] ESC_OFF_CTX_LO = 8'h30;
	localparam logic [7:0] ESC_OFF_CTX_HI = 8'h34;
	localparam logic [7:0] ESC_OFF_KEY_LO = 8'h38;
	localparam logic [7:0] ESC_OFF_KEY_HI = 8'h3c;

	// ****************************************
	// Field positions and codes
	// ****************************************
	localparam int ESC_FC_LOCK_BIT = 0;
	localparam int ESC_FC_LEWR_BIT = 17;
	localparam int ESC_FC_EN_BIT = 18;
	localparam logic [31:0] ESC_LEAF_SET_CONTEXT = 32'h0000_0002;
	localparam logic [63:0] ESC_PAGE_CONFLICT_CODE = 64'h0000_0000_0000_0007;
	localparam logic [7:0] ESC_CONTROL_PAGE_TYPE = 8'h00;
	localparam int ESC_PAGE_ALIGN_BITS = 12;
	localparam int ESC_CTX_ALIGN_BITS = 3;
	localparam logic [31:0] ESC_FEAT_RESET = 32'h0000_0000;
	localparam logic [31:0] ESC_MODE_RESET = 32'h0000_0000;

	// Fault kinds reported in the result register
	typedef enum logic [2:0] {
		ESC_RES_OK = 3'h0,
		ESC_RES_CONFLICT = 3'h1,
		ESC_RES_GP = 3'h2,
		ESC_RES_PF = 3'h3,
		ESC_RES_UD = 3'h4
	} esc_res_e;

	// Engine states, one-hot
	typedef enum logic [5:0] {
		ESC_ST_IDLE = 6'b000001,
		ESC_ST_LOOKUP = 6'b000010,
		ESC_ST_LOAD = 6'b000100,
		ESC_ST_CHECK = 6'b001000,
		ESC_ST_WRITE = 6'b010000,
		ESC_ST_DONE = 6'b100000
	} esc_state_e;

	// Processor mode inputs
	typedef struct packed {
		logic protected_mode;
		logic smm;
		logic v86;
		logic paging;
		logic long64;
		logic ds_unusable;
	} esc_mode_s;

	// Page-map answer for the target page
	typedef struct packed {
		logic in_cache;
		logic valid;
		logic busy;
		logic [7:0] page_type;
	} esc_pmap_s;

	// Flag results
	typedef struct packed {
		logic zf;
		logic cf;
		logic pf;
		logic af;
		logic of_f;
		logic sf;
	} esc_flags_s;

endpackage

// *** tb/esc_engine_checker.sv ***
// Port checker for the set-context engine register bus and interrupt
module esc_chk (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ****
	// Handshake rules
	// ****
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer moved");
	property p_b_ok; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
	a_b_ok: assert property (p_b_ok) else $error("write response not okay");
	// Answer latency after both write halves, or the read address, are taken
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	property p_b_time; s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
	a_b_time: assert property (p_b_time) else $error("write answer late");
	property p_r_time; s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid; endproperty
	a_r_time: assert property (p_r_time) else $error("read answer late");
	property p_ar_busy; s_axi_arvalid && s_axi_arready |=> !s_axi_arready; endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("second read accepted");
	property p_aw_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("write accepted while answering");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready);
	endproperty
	a_b_done: assert property (p_b_done) else $error("write path not reopened");
	// Unmapped reads carry no data
	property p_slverr;
		s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_slverr: assert property (p_slverr) else $error("bad error read");
	c_wr: cover property (s_wr_take);
	c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	c_irq: cover property ($rose(irq));
endmodule

// *** tb/esc_engine_tb.sv ***
// Self-checking bench for the set-context engine
module esc_engine_tb
	import esc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] M64 = 32'h26;
	localparam logic [31:0] PG = 32'h5000;
	localparam logic [31:0] LF = ESC_LEAF_SET_CONTEXT;
	logic sys_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb = 4'hf;
	esc_pmap_s pmap_info = 11'h600;
	logic ds_limit_fault = 1'h0, paging_fault_rcx = 1'h0, paging_fault_rdx = 1'h0;
	logic page_create_pulse = 1'h0;
	logic [63:0] mem_rdata = 64'h0123_4567_89ab_cdef;
	logic [63:0] page_create_addr = 64'h0, ctx_exp = 64'h0;
	logic [31:0] bad [4] = '{32'h06, 32'h36, 32'h2e, 32'h22};
	logic [31:0] d;
	logic [1:0] r;
	int errors = 0;
	int check_count = 0;

	esc_engine u_dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pmap_info,
		.ds_limit_fault, .paging_fault_rcx, .paging_fault_rdx, .mem_rdata,
		.page_create_pulse, .page_create_addr, .irq);

	// Clock, 50 ns period
	always #25 sys_clk = ~sys_clk;

	// ****
	// Bus and compare tasks
	// ****
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got %h want %h", $time, g, e);
		end
	endtask
	// Address and data offered together, each released when taken
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task cx;
		rd(ESC_OFF_CTX_LO, d, r);
		chk(d, ctx_exp[31:0]);
		rd(ESC_OFF_CTX_HI, d, r);
		chk(d, ctx_exp[63:32]);
	endtask
	// One leaf run: load operands, start, wait for idle, check results
	task lv(input logic [31:0] ea, rl, rh, dl, md, input esc_pmap_s pm,
		input logic [2:0] f, input esc_res_e er);
		int n;
		pmap_info <= pm;
		{ds_limit_fault, paging_fault_rcx, paging_fault_rdx} <= f;
		wr(ESC_OFF_MODE, md);
		wr(ESC_OFF_RCX_LO, rl);
		wr(ESC_OFF_RCX_HI, rh);
		wr(ESC_OFF_RDX_LO, dl);
		wr(ESC_OFF_RDX_HI, 32'h0);
		wr(ESC_OFF_RAX_LO, ea);
		wr(ESC_OFF_CTRL, 32'h1);
		n = 0;
		d = 32'h1;
		while (d[0] !== 1'h0 && n < 20) begin
			rd(ESC_OFF_CTRL, d, r);
			n++;
		end
		chk(d, 32'h0);
		rd(ESC_OFF_RESULT, d, r);
		chk(d, {29'h0, er});
		if (er == ESC_RES_OK) ctx_exp = mem_rdata;
		cx();
		if (er == ESC_RES_OK || er == ESC_RES_CONFLICT) begin
			rd(ESC_OFF_STAT, d, r);
			chk(d, (er == ESC_RES_OK) ? 32'h0 : 32'h20);
			rd(ESC_OFF_RAX_LO, d, r);
			chk(d, (er == ESC_RES_OK) ? 32'h0 : ESC_PAGE_CONFLICT_CODE[31:0]);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog, far beyond the expected run
	initial begin
		#3_000_000;
		errors++;
		complete_run();
	end

	// ****
	// Test sequence
	// ****
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'h0;
		wr(ESC_OFF_KEY_LO, 32'hcafe_0001);
		rd(ESC_OFF_KEY_LO, d, r);
		chk(d, 32'h0);
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h600, 3'h0, ESC_RES_UD);
		wr(ESC_OFF_FEAT, 32'h0006_0000);
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h600, 3'h0, ESC_RES_UD);
		wr(ESC_OFF_KEY_LO, 32'hcafe_0001);
		rd(ESC_OFF_KEY_LO, d, r);
		chk(d, 32'h0);
		wr(ESC_OFF_FEAT, 32'h0006_0001);
		wr(ESC_OFF_FEAT, 32'h0);
		rd(ESC_OFF_FEAT, d, r);
		chk(d, 32'h0006_0001);
		wr(ESC_OFF_KEY_LO, 32'hcafe_0001);
		rd(ESC_OFF_KEY_LO, d, r);
		chk(d, 32'hcafe_0001);
		$display("done: feature gating");
		foreach (bad[i]) lv(LF, PG, 32'h0, 32'h8, bad[i], 11'h600, 3'h0, ESC_RES_UD);
		lv(32'h3, PG, 32'h0, 32'h8, M64, 11'h600, 3'h0, ESC_RES_UD);
		$display("done: mode gating");
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h600, 3'h0, ESC_RES_OK);
		mem_rdata <= 64'hfedc_ba98_7654_3210;
		lv(LF, PG, 32'h0, 32'h10, M64, 11'h600, 3'h0, ESC_RES_OK);
		lv(LF, 32'h5800, 32'h0, 32'h8, M64, 11'h200, 3'h0, ESC_RES_GP);
		lv(LF, PG, 32'h0, 32'h4, M64, 11'h200, 3'h0, ESC_RES_PF);
		lv(LF, PG, 32'h0, 32'h4, M64, 11'h700, 3'h0, ESC_RES_GP);
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h700, 3'h1, ESC_RES_PF);
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h700, 3'h0, ESC_RES_CONFLICT);
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h500, 3'h0, ESC_RES_CONFLICT);
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h400, 3'h0, ESC_RES_PF);
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h601, 3'h0, ESC_RES_PF);
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h600, 3'h2, ESC_RES_PF);
		lv(LF, PG, 32'h0, 32'h8, 32'h24, 11'h600, 3'h4, ESC_RES_GP);
		lv(LF, PG, 32'h0, 32'h8, 32'h25, 11'h600, 3'h0, ESC_RES_GP);
		lv(LF, PG, 32'h0001_0000, 32'h8, M64, 11'h600, 3'h0, ESC_RES_GP);
		$display("done: leaf checks");
		page_create_addr <= 64'h0000_0000_0000_9000;
		page_create_pulse <= 1'h1;
		@(posedge sys_clk);
		page_create_pulse <= 1'h0;
		ctx_exp = 64'h0000_0000_0000_9000;
		cx();
		$display("done: control page create");
		// Interrupt: raise, mask, clear by read
		rd(ESC_OFF_EVT, d, r);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		wr(ESC_OFF_MASK, 32'h1);
		lv(LF, PG, 32'h0, 32'h8, M64, 11'h600, 3'h0, ESC_RES_OK);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		wr(ESC_OFF_MASK, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		wr(ESC_OFF_MASK, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		rd(ESC_OFF_EVT, d, r);
		chk(d, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		$display("done: interrupt");
		wr(8'h40, 32'h1234_5678);
		rd(8'h40, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, 32'h2);
		$display("done: unmapped access");
		complete_run();
	end
endmodule

// Checker attached to every engine instance
bind esc_engine esc_chk u_chk (.sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .irq);
